// >>> plrc_bank_props.sv
// Concurrent checks on the ports of the PLL reconfiguration register bank
`timescale 1ns/100ps
module plrc_bank_props #(
  parameter logic [31:0] INSTANCE_ID = 32'h0000_0001
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [10:0] reg_addr_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        pll_locked_in,
  input wire logic        pll_powerdown_in,
  input wire logic        pll_powerdown_out,
  input wire logic        cal_step_ack_in,
  input wire logic        cal_step_start_out,
  input wire logic        cal_step_tx_out,
  input wire logic        cal_busy_out,
  input wire logic        cfg_bus_engine_out,
  input wire logic        stream_start_out,
  input wire logic [2:0]  stream_profile_out
);
  // ---------------------------------------------------------------
  // Mirrors of written controls
  // ---------------------------------------------------------------
  logic rx_en, tx_en, ovr, pd_bit, exp_pd;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {rx_en, tx_en, ovr, pd_bit, exp_pd} <= '0;
    end else begin
      if (reg_write_in && reg_addr_in == plrc_pkg::OFF_CAL) {tx_en, rx_en} <= reg_wdata_in[1:0];
      // Power-down follows a new override at the very edge that writes it
      if (reg_write_in && reg_addr_in == plrc_pkg::OFF_PD) begin
        {ovr, pd_bit} <= reg_wdata_in[1:0];
        exp_pd        <= reg_wdata_in[1] ? reg_wdata_in[0] : pll_powerdown_in;
      end else begin
        exp_pd <= ovr ? pd_bit : pll_powerdown_in;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  chk_id_byte: assert property (reg_read_in && reg_addr_in == plrc_pkg::OFF_ID0
    |=> reg_rdata_out == INSTANCE_ID[7:0]) else $error("bad id byte");
  chk_lock_live: assert property (reg_read_in && reg_addr_in == plrc_pkg::OFF_STATUS
    |=> reg_rdata_out[0] == $past(pll_locked_in)) else $error("bad lock bit");
  chk_done_inverse: assert property (reg_read_in && reg_addr_in == plrc_pkg::OFF_ARB
    |=> reg_rdata_out[1] == !$past(cal_busy_out)) else $error("bad done bit");
  chk_busy_owner: assert property (cal_busy_out |-> cfg_bus_engine_out)
    else $error("owner low while busy");
  chk_rx_first: assert property ($rose(cal_busy_out) && rx_en
    |-> cal_step_start_out && !cal_step_tx_out) else $error("rx not first");
  chk_tx_follow: assert property (cal_busy_out && cal_step_ack_in && !cal_step_tx_out && tx_en
    |=> cal_step_start_out && cal_step_tx_out) else $error("tx step missing");
  chk_busy_end: assert property (cal_busy_out && cal_step_ack_in && cal_step_tx_out
    |=> cal_busy_out ##1 !cal_busy_out) else $error("busy end wrong");
  chk_start_clear: assert property (stream_start_out |=> !stream_start_out)
    else $error("start not cleared");
  chk_prof_latch: assert property (reg_write_in && reg_addr_in == plrc_pkg::OFF_PROF
    |=> stream_profile_out == $past(reg_wdata_in[2:0])) else $error("bad profile");
  chk_pd_follow: assert property (pll_powerdown_out == exp_pd)
    else $error("bad power-down");
  cover property (cal_step_start_out && cal_step_tx_out);
  cover property (stream_start_out);
  cover property (ovr && pll_powerdown_out);
endmodule : plrc_bank_props
bind plrc_reg_bank plrc_bank_props #(.INSTANCE_ID(INSTANCE_ID)) u_props (.*);

// >>> plrc_cal_seq.sv
// Calibration step sequencer: receive step first, then transmit step
`timescale 1ns/100ps
module plrc_cal_seq (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic go_in,
  input  wire logic rx_en_in,
  input  wire logic tx_en_in,
  input  wire logic step_ack_in,
  output logic      step_start_out,
  output logic      step_tx_out,
  output logic      busy_out
);

  typedef struct packed {
    plrc_pkg::plrc_cal_state_t state;
    logic                      tx_pend;
    logic                      start;
    logic                      tx;
    logic                      busy;
  } plrc_seq_t;

  plrc_seq_t cur;
  plrc_seq_t next_cur;

  always_comb begin
    next_cur       = cur;
    next_cur.start = 1'b0;
    case (cur.state)
      plrc_pkg::CAL_IDLE: begin
        if (go_in && (rx_en_in || tx_en_in)) begin
          next_cur.tx_pend = tx_en_in && rx_en_in;
          next_cur.start   = 1'b1;
          // Receive always goes first when both are enabled
          if (rx_en_in) begin
            next_cur.state = plrc_pkg::CAL_RX;
            next_cur.tx    = 1'b0;
          end else begin
            next_cur.state = plrc_pkg::CAL_TX;
            next_cur.tx    = 1'b1;
          end
        end
      end
      plrc_pkg::CAL_RX: begin
        if (step_ack_in) begin
          if (cur.tx_pend) begin
            next_cur.state = plrc_pkg::CAL_TX;
            next_cur.start = 1'b1;
            next_cur.tx    = 1'b1;
          end else begin
            next_cur.state = plrc_pkg::CAL_FIN;
          end
        end
      end
      plrc_pkg::CAL_TX: begin
        if (step_ack_in) begin
          next_cur.state = plrc_pkg::CAL_FIN;
        end
      end
      plrc_pkg::CAL_FIN: begin
        next_cur.state   = plrc_pkg::CAL_IDLE;
        next_cur.tx_pend = 1'b0;
      end
      default: begin
        next_cur.state = plrc_pkg::CAL_IDLE;
      end
    endcase
    // Busy stays up until every enabled step has finished
    next_cur.busy = (next_cur.state != plrc_pkg::CAL_IDLE);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign step_start_out = cur.start;
  assign step_tx_out    = cur.tx;
  assign busy_out       = cur.busy;

endmodule : plrc_cal_seq

// >>> plrc_far_model.sv
// Far-side responder: calibration steps and profile streamer
`timescale 1ns/100ps
module plrc_far_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       step_start_in,
  input  wire logic       stream_start_in,
  output logic            step_ack_out,
  output logic            stream_done_out
);
  // ---------------------------------------------------------------
  // Two delayed one-shot answers
  // ---------------------------------------------------------------
  logic [1:0] go, run, hit;
  logic [3:0] cnt [2];
  assign go = {stream_start_in, step_start_in};
  assign step_ack_out = hit[0];
  assign stream_done_out = hit[1];
  // Slow answers matter most: busy must span the whole wait
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run <= '0;
      hit <= '0;
      cnt <= '{4'h0, 4'h0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        hit[i] <= 1'b0;
        if (go[i]) begin
          run[i] <= 1'b1;
          cnt[i] <= delay_in;
        end else if (run[i]) begin
          cnt[i] <= cnt[i] - 4'h1;
          hit[i] <= cnt[i] == 4'h0;
          run[i] <= cnt[i] != 4'h0;
        end
      end
    end
  end
endmodule : plrc_far_model

// >>> plrc_pkg.sv
// Constants, register map and state encodings of the PLL reconfiguration register bank
package plrc_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int PROF_W = 3;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_ARB     = 11'h000;
  localparam logic [ADDR_W-1:0] OFF_CAL     = 11'h100;
  localparam logic [ADDR_W-1:0] OFF_ID0     = 11'h400;
  localparam logic [ADDR_W-1:0] OFF_ID1     = 11'h401;
  localparam logic [ADDR_W-1:0] OFF_ID2     = 11'h402;
  localparam logic [ADDR_W-1:0] OFF_ID3     = 11'h403;
  localparam logic [ADDR_W-1:0] OFF_STAT_EN = 11'h404;
  localparam logic [ADDR_W-1:0] OFF_CTRL_EN = 11'h405;
  localparam logic [ADDR_W-1:0] OFF_MCGB    = 11'h410;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 11'h480;
  localparam logic [ADDR_W-1:0] OFF_PD      = 11'h4e0;
  localparam logic [ADDR_W-1:0] OFF_PROF    = 11'h540;
  localparam logic [ADDR_W-1:0] OFF_SBUSY   = 11'h541;
  localparam logic [ADDR_W-1:0] OFF_BGCAL   = 11'h542;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_ARB      = 0;
  localparam int BIT_CAL_DONE = 1;
  localparam int BIT_TANK_CAL = 0;
  localparam int BIT_TANK_PRE = 1;
  localparam int BIT_RX_CAL   = 0;
  localparam int BIT_TX_CAL   = 1;
  localparam int BIT_MULT_PRE = 3;
  localparam int BIT_PRESENT  = 0;
  localparam int BIT_LOCK     = 0;
  localparam int BIT_CAL_BUSY = 1;
  localparam int BIT_OWNER    = 2;
  localparam int BIT_PD       = 0;
  localparam int BIT_PD_OVR   = 1;
  localparam int PROF_LSB     = 0;
  localparam int BIT_LOAD     = 7;
  localparam int BIT_SBUSY    = 0;
  localparam int BIT_BGCAL    = 0;
  localparam int ID_BYTES     = 4;

  // ---------------------------------------------------------------
  // Reset values and variants
  // ---------------------------------------------------------------
  localparam logic              RST_ARB  = 1'b1;
  localparam logic              RST_BIT  = 1'b0;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PROF_W-1:0] RST_PROF = 3'h0;
  localparam logic              VAR_TANK = 1'b0;
  localparam logic              VAR_MULT = 1'b1;

  // ---------------------------------------------------------------
  // Calibration sequencer states, Gray along idle-rx-tx-fin
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_RX   = 2'h1,
    CAL_TX   = 2'h3,
    CAL_FIN  = 2'h2
  } plrc_cal_state_t;

endpackage : plrc_pkg

// >>> plrc_reg_bank.sv
// Reconfiguration register bank of one transmit PLL, tank or multiplier variant
//
// Overview of operation
// - Offset 0x000 bit 0: 0 gives host the config bus, 1 hands it to engine.
// - Offset 0x000 bit 1 reads calibration done, inverse of calibration busy.
// - Multiplier variant calibrates receive then transmit; done only after every enabled step.
// - Tank variant: offset 0x100 bit 0 enables PLL calibration.
// - Tank variant: offset 0x100 bit 1 requests reconfiguration mode from engine.
// - Multiplier variant: offset 0x100 bit 0 enables receive calibration.
// - Multiplier variant: offset 0x100 bit 1 enables transmit calibration.
// - Receiver use: offset 0x100 bit 3 selects register bandwidth; resets to 0.
// - Multiplier PLL use: offset 0x100 bit 3 requests reconfiguration mode.
// - Multiplier variant: offset 0x542 bit 0 runs background calibration if built in.
// - Offsets 0x400 to 0x403 read back the 32-bit instance identifier.
// - Offset 0x404 bit 0 reads 1 when status registers are built in.
// - Offset 0x405 bit 0 reads 1 when control registers are built in.
// - Tank variant: offset 0x410 bit 0 reads 1 when clock generation block present.
// - Offset 0x480 bit 0 reads PLL lock.
// - Offset 0x480 bit 1 reads 1 while PLL calibration runs.
// - Offset 0x480 bit 2 reads 1 while engine owns the config bus.
// - Offset 0x4e0: bit 1 overrides power-down, bit 0 then drives it.
// - Offset 0x540 bits 2:0 pick one of eight streamed profiles.
// - Offset 0x540 bit 7 starts streaming and clears itself.
// - Offset 0x541 bit 0 reads 1 while streaming is in progress.
`timescale 1ns/100ps
module plrc_reg_bank #(
  parameter logic        VARIANT        = plrc_pkg::VAR_TANK,
  parameter logic        MULT_AS_RX     = 1'b0,
  parameter logic [31:0] INSTANCE_ID    = 32'h0000_0001, // Arbitrary value
  parameter logic        STATUS_PRESENT = 1'b1,
  parameter logic        CTRL_PRESENT   = 1'b1,
  parameter logic        MCGB_PRESENT   = 1'b0,
  parameter logic        BG_CAL_BUILT   = 1'b0
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic [plrc_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic                         reg_write_in,
  input  wire logic                         reg_read_in,
  input  wire logic [plrc_pkg::DATA_W-1:0]  reg_wdata_in,
  output logic      [plrc_pkg::DATA_W-1:0]  reg_rdata_out,
  output logic                              reg_rvalid_out,
  input  wire logic                         pll_locked_in,
  input  wire logic                         pll_powerdown_in,
  output logic                              pll_powerdown_out,
  input  wire logic                         cal_step_ack_in,
  output logic                              cal_step_start_out,
  output logic                              cal_step_tx_out,
  output logic                              cal_busy_out,
  output logic                              cfg_bus_engine_out,
  output logic                              prereconfig_req_out,
  output logic                              cdr_bw_from_regs_out,
  output logic                              bg_cal_enable_out,
  output logic                              stream_start_out,
  output logic      [plrc_pkg::PROF_W-1:0]  stream_profile_out,
  input  wire logic                         stream_done_in
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                        arb;
    logic [plrc_pkg::DATA_W-1:0] cal_reg;
    logic                        pd_val;
    logic                        pd_ovr;
    logic [plrc_pkg::PROF_W-1:0] prof_sel;
    logic                        load;
    logic                        stream_busy;
    logic                        stream_start;
    logic                        bg_cal;
    logic                        cal_go;
    logic [plrc_pkg::DATA_W-1:0] rdata;
    logic                        rvalid;
    logic                        pll_pd;
    logic                        owner;
    logic                        pre_req;
    logic                        cdr_bw;
    logic                        bg_out;
  } plrc_bank_t;

  plrc_bank_t cur;
  plrc_bank_t next_cur;

  logic cal_busy;
  logic rx_en;
  logic tx_en;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [plrc_pkg::ADDR_W-1:0] addr,
                               input logic [plrc_pkg::ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  // Bits of offset 0x100 that exist in the chosen variant
  function automatic logic [plrc_pkg::DATA_W-1:0] cal_mask(input logic variant);
    logic [plrc_pkg::DATA_W-1:0] m;
    m = plrc_pkg::RST_BYTE;
    if (variant == plrc_pkg::VAR_TANK) begin
      m[plrc_pkg::BIT_TANK_CAL] = 1'b1;
      m[plrc_pkg::BIT_TANK_PRE] = 1'b1;
    end else begin
      m[plrc_pkg::BIT_RX_CAL]   = 1'b1;
      m[plrc_pkg::BIT_TX_CAL]   = 1'b1;
      m[plrc_pkg::BIT_MULT_PRE] = 1'b1;
    end
    cal_mask = m;
  endfunction : cal_mask

  function automatic logic [plrc_pkg::DATA_W-1:0] flag(input logic b, input int pos);
    logic [plrc_pkg::DATA_W-1:0] f;
    f      = plrc_pkg::RST_BYTE;
    f[pos] = b;
    flag   = f;
  endfunction : flag

  // ---------------------------------------------------------------
  // Calibration enables towards the sequencer
  // ---------------------------------------------------------------
  // The tank variant has a single PLL step; it rides on the receive slot
  assign rx_en = (VARIANT == plrc_pkg::VAR_TANK) ?
                 cur.cal_reg[plrc_pkg::BIT_TANK_CAL] :
                 cur.cal_reg[plrc_pkg::BIT_RX_CAL];
  assign tx_en = (VARIANT == plrc_pkg::VAR_MULT) &&
                 cur.cal_reg[plrc_pkg::BIT_TX_CAL];

  plrc_cal_seq u_cal_seq (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .go_in          (cur.cal_go),
    .rx_en_in       (rx_en),
    .tx_en_in       (tx_en),
    .step_ack_in    (cal_step_ack_in),
    .step_start_out (cal_step_start_out),
    .step_tx_out    (cal_step_tx_out),
    .busy_out       (cal_busy)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur              = cur;
    next_cur.rvalid       = 1'b0;
    next_cur.cal_go       = 1'b0;
    next_cur.stream_start = 1'b0;
    next_cur.load         = 1'b0;

    // Streaming end clears busy; a start in the same cycle is still dropped below
    if (stream_done_in) begin
      next_cur.stream_busy = 1'b0;
    end

    if (reg_write_in) begin
      if (hit(reg_addr_in, plrc_pkg::OFF_ARB)) begin
        next_cur.arb = reg_wdata_in[plrc_pkg::BIT_ARB];
        // Handing the bus over is what launches an enabled calibration
        if (reg_wdata_in[plrc_pkg::BIT_ARB] && !cur.arb && !cal_busy) begin
          next_cur.cal_go = 1'b1;
        end
      end
      if (hit(reg_addr_in, plrc_pkg::OFF_CAL)) begin
        next_cur.cal_reg = reg_wdata_in & cal_mask(VARIANT);
      end
      if (hit(reg_addr_in, plrc_pkg::OFF_PD)) begin
        next_cur.pd_val = reg_wdata_in[plrc_pkg::BIT_PD];
        next_cur.pd_ovr = reg_wdata_in[plrc_pkg::BIT_PD_OVR];
      end
      if (hit(reg_addr_in, plrc_pkg::OFF_PROF)) begin
        next_cur.prof_sel = reg_wdata_in[plrc_pkg::PROF_LSB +: plrc_pkg::PROF_W];
        // A start while a stream runs is dropped rather than queued
        if (reg_wdata_in[plrc_pkg::BIT_LOAD] && !cur.stream_busy) begin
          next_cur.load         = 1'b1;
          next_cur.stream_start = 1'b1;
          next_cur.stream_busy  = 1'b1;
        end
      end
      if (hit(reg_addr_in, plrc_pkg::OFF_BGCAL) && (VARIANT == plrc_pkg::VAR_MULT)) begin
        next_cur.bg_cal = reg_wdata_in[plrc_pkg::BIT_BGCAL];
      end
    end

    if (reg_read_in) begin
      next_cur.rvalid = 1'b1;
      case (reg_addr_in)
        plrc_pkg::OFF_ARB: begin
          next_cur.rdata = flag(cur.arb, plrc_pkg::BIT_ARB) |
                           flag(!cal_busy, plrc_pkg::BIT_CAL_DONE);
        end
        plrc_pkg::OFF_CAL: begin
          next_cur.rdata = cur.cal_reg;
        end
        plrc_pkg::OFF_ID0: begin
          next_cur.rdata = INSTANCE_ID[0*plrc_pkg::DATA_W +: plrc_pkg::DATA_W];
        end
        plrc_pkg::OFF_ID1: begin
          next_cur.rdata = INSTANCE_ID[1*plrc_pkg::DATA_W +: plrc_pkg::DATA_W];
        end
        plrc_pkg::OFF_ID2: begin
          next_cur.rdata = INSTANCE_ID[2*plrc_pkg::DATA_W +: plrc_pkg::DATA_W];
        end
        plrc_pkg::OFF_ID3: begin
          next_cur.rdata = INSTANCE_ID[3*plrc_pkg::DATA_W +: plrc_pkg::DATA_W];
        end
        plrc_pkg::OFF_STAT_EN: begin
          next_cur.rdata = flag(STATUS_PRESENT, plrc_pkg::BIT_PRESENT);
        end
        plrc_pkg::OFF_CTRL_EN: begin
          next_cur.rdata = flag(CTRL_PRESENT, plrc_pkg::BIT_PRESENT);
        end
        plrc_pkg::OFF_MCGB: begin
          next_cur.rdata = flag(MCGB_PRESENT && (VARIANT == plrc_pkg::VAR_TANK),
                                plrc_pkg::BIT_PRESENT);
        end
        plrc_pkg::OFF_STATUS: begin
          next_cur.rdata = flag(pll_locked_in, plrc_pkg::BIT_LOCK) |
                           flag(cal_busy, plrc_pkg::BIT_CAL_BUSY) |
                           flag(cur.owner, plrc_pkg::BIT_OWNER);
        end
        plrc_pkg::OFF_PD: begin
          next_cur.rdata = flag(cur.pd_val, plrc_pkg::BIT_PD) |
                           flag(cur.pd_ovr, plrc_pkg::BIT_PD_OVR);
        end
        plrc_pkg::OFF_PROF: begin
          next_cur.rdata = flag(cur.load, plrc_pkg::BIT_LOAD);
          next_cur.rdata[plrc_pkg::PROF_LSB +: plrc_pkg::PROF_W] = cur.prof_sel;
        end
        plrc_pkg::OFF_SBUSY: begin
          next_cur.rdata = flag(cur.stream_busy, plrc_pkg::BIT_SBUSY);
        end
        plrc_pkg::OFF_BGCAL: begin
          next_cur.rdata = flag(cur.bg_cal, plrc_pkg::BIT_BGCAL);
        end
        default: begin
          // Unmapped offsets read as zero
          next_cur.rdata = plrc_pkg::RST_BYTE;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // Registered side outputs
    // ---------------------------------------------------------------
    // Without the override the default power-down source passes through
    next_cur.pll_pd = next_cur.pd_ovr ? next_cur.pd_val : pll_powerdown_in;
    // Engine keeps the bus while a calibration it started is still running
    // A pending launch counts too, so ownership never trails busy by a cycle
    next_cur.owner  = next_cur.arb || cal_busy || cur.cal_go;
    if (VARIANT == plrc_pkg::VAR_TANK) begin
      next_cur.pre_req = next_cur.cal_reg[plrc_pkg::BIT_TANK_PRE];
      next_cur.cdr_bw  = 1'b0;
    end else if (MULT_AS_RX) begin
      next_cur.pre_req = 1'b0;
      next_cur.cdr_bw  = next_cur.cal_reg[plrc_pkg::BIT_MULT_PRE];
    end else begin
      next_cur.pre_req = next_cur.cal_reg[plrc_pkg::BIT_MULT_PRE];
      next_cur.cdr_bw  = 1'b0;
    end
    // Has no effect unless background calibration was built in
    next_cur.bg_out = next_cur.bg_cal && BG_CAL_BUILT &&
                      (VARIANT == plrc_pkg::VAR_MULT);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur              <= '0;
      cur.arb          <= plrc_pkg::RST_ARB;
      cur.cal_reg      <= plrc_pkg::RST_BYTE;
      cur.prof_sel     <= plrc_pkg::RST_PROF;
      cur.pd_val       <= plrc_pkg::RST_BIT;
      cur.pd_ovr       <= plrc_pkg::RST_BIT;
      cur.owner        <= plrc_pkg::RST_ARB;
      cur.rdata        <= plrc_pkg::RST_BYTE;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out        = cur.rdata;
  assign reg_rvalid_out       = cur.rvalid;
  assign pll_powerdown_out    = cur.pll_pd;
  assign cal_busy_out         = cal_busy;
  assign cfg_bus_engine_out   = cur.owner;
  assign prereconfig_req_out  = cur.pre_req;
  assign cdr_bw_from_regs_out = cur.cdr_bw;
  assign bg_cal_enable_out    = cur.bg_out;
  assign stream_start_out     = cur.stream_start;
  assign stream_profile_out   = cur.prof_sel;

endmodule : plrc_reg_bank

// >>> plrc_reg_bank_test.sv
// Self-checking testbench of the PLL reconfiguration register bank
`timescale 1ns/100ps
module plrc_reg_bank_test;
  localparam logic [31:0] ID_VAL = 32'h5a3c_9617; // Arbitrary value
  localparam logic [10:0] CAP_A [8] = '{11'h400, 11'h401, 11'h402, 11'h403,
                                        11'h404, 11'h405, 11'h410, 11'h7ff};
  localparam logic [7:0]  CAP_E [8] = '{ID_VAL[7:0], ID_VAL[15:8], ID_VAL[23:16],
                                        ID_VAL[31:24], 8'h01, 8'h01, 8'h00, 8'h00};
  logic        clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, lock = 1'b0, pd_in = 1'b0;
  logic        rv, ack, st, tx, busy, own, pre, cdr, bg, s_go, s_done, pd_out;
  logic [10:0] addr = 11'h000;
  logic [7:0]  wd = 8'h00, rdat, got;
  logic [2:0]  prof;
  logic [3:0]  dly = 4'h4;
  logic        txq [$];
  int          err_count = 0, n_tests = 0, seed = 63770, w;
  always #12.5 clk_in = ~clk_in;
  always @(negedge clk_in) if (st === 1'b1) txq.push_back(tx);
  plrc_reg_bank #(.VARIANT(plrc_pkg::VAR_MULT), .INSTANCE_ID(ID_VAL), .BG_CAL_BUILT(1'b1)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_write_in(wr),
    .reg_read_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
    .pll_locked_in(lock), .pll_powerdown_in(pd_in), .pll_powerdown_out(pd_out),
    .cal_step_ack_in(ack), .cal_step_start_out(st), .cal_step_tx_out(tx),
    .cal_busy_out(busy), .cfg_bus_engine_out(own), .prereconfig_req_out(pre),
    .cdr_bw_from_regs_out(cdr), .bg_cal_enable_out(bg), .stream_start_out(s_go),
    .stream_profile_out(prof), .stream_done_in(s_done));
  plrc_far_model u_far (.clk_in(clk_in), .rst_in(rst_in), .delay_in(dly), .step_start_in(st),
    .stream_start_in(s_go), .step_ack_out(ack), .stream_done_out(s_done));
  // ---------------------------------------------------------------
  // Bus tasks and verdict
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [10:0] a);
    @(negedge clk_in);
    addr = a;
    lock = 1'($random(seed));
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    got = (rv === 1'b1) ? rdat : 8'hxx;
  endtask : rreg
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    chk(8'({own, pre, s_go, prof}), 8'h20);
    rreg(plrc_pkg::OFF_ARB);
    chk(got, 8'h03);
    rreg(plrc_pkg::OFF_CAL);
    chk(got, 8'h00);
    wreg(plrc_pkg::OFF_STAT_EN, 8'hff);
    for (int i = 0; i < 8; i++) begin
      rreg(CAP_A[i]);
      chk(got, CAP_E[i]);
    end
    wreg(plrc_pkg::OFF_ARB, 8'h00);
    chk(8'(own), 8'h00);
    rreg(plrc_pkg::OFF_STATUS);
    chk(got, 8'(lock));
    repeat (6) begin
      w = $random(seed);
      pd_in = w[2];
      wreg(plrc_pkg::OFF_PD, 8'(w[1:0]));
      @(negedge clk_in);
      chk(8'(pd_out), 8'(w[1] ? w[0] : w[2]));
    end
    for (int p = 0; p < 8; p++) begin
      dly = 4'h4 | 4'($random(seed));
      wreg(plrc_pkg::OFF_PROF, 8'h80 | 8'(p));
      chk(8'({s_go, prof}), 8'(8 + p));
      rreg(plrc_pkg::OFF_PROF);
      chk(got, 8'(p));
      rreg(plrc_pkg::OFF_SBUSY);
      chk(got, 8'h01);
      for (w = 0; w < 30 && got !== 8'h00; w++) rreg(plrc_pkg::OFF_SBUSY);
      chk(got, 8'h00);
    end
    for (int e = 1; e < 4; e++) begin
      wreg(plrc_pkg::OFF_ARB, 8'h00);
      wreg(plrc_pkg::OFF_CAL, 8'(e));
      txq.delete();
      wreg(plrc_pkg::OFF_ARB, 8'h01);
      rreg(plrc_pkg::OFF_STATUS);
      chk(got, 8'h06 | 8'(lock));
      for (w = 0; w < 40 && got !== 8'h03; w++) rreg(plrc_pkg::OFF_ARB);
      chk(got, 8'h03);
      chk(8'(txq.size()), (e == 3) ? 8'h02 : 8'h01);
      chk(8'(txq[0]), 8'(e == 2));
      chk(8'(txq[txq.size() - 1]), 8'(e != 1));
    end
    wreg(plrc_pkg::OFF_ARB, 8'h00);
    wreg(plrc_pkg::OFF_CAL, 8'h08);
    wreg(plrc_pkg::OFF_BGCAL, 8'h01);
    rreg(plrc_pkg::OFF_BGCAL);
    chk(got, 8'h01);
    chk(8'({pre, cdr, bg}), 8'h05);
    wreg(plrc_pkg::OFF_BGCAL, 8'h00);
    chk(8'(bg), 8'h00);
    wreg(plrc_pkg::OFF_ARB, 8'h01);
    complete_run();
  end
  initial begin
    #(25 * 6000);
    err_count++;
    complete_run();
  end
endmodule : plrc_reg_bank_test
